// File: fhrp_consts.svh
`ifndef FHRP_CONSTS_SVH
`define FHRP_CONSTS_SVH

// configuration register word address and reset value
`define FHRP_CFG_ADDR 16'hf221
`define FHRP_CFG_RESET 16'h4000

// configuration field positions
`define FHRP_RM_BIT 15
`define FHRP_BRL_MSB 14
`define FHRP_BRL_LSB 12
`define FHRP_BL_MSB 11
`define FHRP_BL_LSB 9

// burst length codes
`define FHRP_BL_CONT 3'h0
`define FHRP_BL_4 3'h1
`define FHRP_BL_8 3'h2
`define FHRP_BL_16 3'h3
`define FHRP_BL_32 3'h4

// wrap masks for each burst length
`define FHRP_MASK_4 16'h0003
`define FHRP_MASK_8 16'h0007
`define FHRP_MASK_16 16'h000f
`define FHRP_MASK_32 16'h001f
`define FHRP_MASK_CONT 16'hffff
`define FHRP_ADDR_ONE 16'h0001

// regions with no synchronous read support, then the buffer spare area closed to 32-word bursts
`define FHRP_RSV_MAIN_LO 16'h0a00
`define FHRP_RSV_MAIN_HI 16'h7fff
`define FHRP_RSV_SPARE_LO 16'h8050
`define FHRP_RSV_SPARE_HI 16'h8fff
`define FHRP_RSV_REG_LO 16'h9000
`define FHRP_RSV_REG_HI 16'hefff
`define FHRP_BUF_SPARE_LO 16'h8010
`define FHRP_BUF_SPARE_HI 16'h804f

// latency counter constants
`define FHRP_CNT_ZERO 4'h0
`define FHRP_CNT_ONE 4'h1

`endif

// File: fhrp_pkg.sv
package fhrp_pkg;

   // burst engine states, gray coded along idle -> latency -> stream
   typedef enum logic [1:0] {
      FHRP_IDLE = 2'b00,
      FHRP_LATENCY = 2'b01,
      FHRP_STREAM = 2'b11
   } fhrp_state_t;

   // whole state of the read port
   typedef struct packed {
      fhrp_state_t state;
      logic [15:0] cfg;
      logic [15:0] addr;
      logic [15:0] fill_addr;
      logic [3:0] cnt;
      logic rdy;
      logic [15:0] data_out;
      logic bclk_d;
      logic we_d;
   } fhrp_port_t;

endpackage

// File: fhrp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module fhrp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // asynchronous in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_reg;

   // two flops, first one read only by second
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_reg <= INIT;
         q <= INIT;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// File: fhrp_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module fhrp_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clr,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wr_reg;
   logic [AW:0] rd_reg;
   logic push;
   logic pop;

   // honest full and empty from extended pointers
   assign in_ready = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
   assign out_valid = (wr_reg != rd_reg);
   assign out_data = mem[rd_reg[AW-1:0]];
   assign push = in_valid && in_ready && !clr;
   assign pop = out_valid && out_ready && !clr;

   // pointer update, flush on clear
   always_ff @(posedge clk) begin
      if (!rst_n || clr) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
      end
   end

   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg[AW-1:0]] <= in_data;
      end
   end

endmodule

`default_nettype wire

// File: fhrp_top.sv
// How it works
// RULE1: reset enters asynchronous mode, no command needed
// RULE2: read-mode select set enables synchronous burst
// RULE3: async: address latched on strobe, word returned
// RULE4: continuous and fixed-length bursts supported
// RULE5: fixed bursts wrap within aligned group
// RULE6: first word asynchronous, rest follow latency
// RULE7: latency defaults four, programmable to seven
// RULE8: configuration readable during burst via strobe
// RULE9: ready pulses one clock before first fetch
// RULE10: clocked access in async mode still delivers
// RULE11: each later clock edge advances and outputs
// RULE12: burst ends on chip select, write, reset
// RULE13: no synchronous reads in reserved regions
// RULE14: first word taken on edge n plus one
// RULE15: after latency each edge outputs next word
// RULE16: no 32-word burst in buffer spare area
// RULE17: host ends fixed burst with selects high
// RULE18: data lines released when selects high
// RULE19: hardware reset restores registers, keeps memory
// RULE20: termination clears counter, waits for strobe
`timescale 1ns/1ps
`default_nettype none
`include "fhrp_consts.svh"

module fhrp_top #(
   parameter int MEM_AW = 12,
   parameter int FIFO_DEPTH = 16
) (
   // system clock and reset
   input wire logic CLOCK,
   input wire logic RESET_N,
   // device reset pin
   input wire logic HARDWARE_RESET_N,
   // burst clock from the host
   input wire logic BURST_CLK,
   // host control strobes
   input wire logic ADDRESS_VALID_STROBE_N,
   input wire logic CHIP_SELECT_N,
   input wire logic OUTPUT_ENABLE_N,
   input wire logic WRITE_STROBE_N,
   // address and data
   input wire logic [15:0] ADDRESS_LINES,
   input wire logic [15:0] DATA_LINES_IN,
   output logic [15:0] DATA_LINES_OUT,
   output logic DATA_LINES_OE_N,
   // handshake
   output logic READY
);

   localparam logic [5:0] SYNC_INIT = 6'h3e;
   // positions of the pins in the synchronised control word
   localparam int CTL_HRST = 5;
   localparam int CTL_AVD = 4;
   localparam int CTL_CE = 3;
   localparam int CTL_OE = 2;
   localparam int CTL_WE = 1;
   localparam int CTL_BCLK = 0;

   fhrp_pkg::fhrp_port_t r_reg;
   fhrp_pkg::fhrp_port_t r_next;
   logic [15:0] mem [2**MEM_AW];

   logic [5:0] ctl_s;
   logic [15:0] addr_s;
   logic [15:0] din_s;
   logic bclk_s;
   logic avd_n_s;
   logic ce_n_s;
   logic oe_n_s;
   logic we_n_s;
   logic hrst_n_s;
   logic warm_rst_n;
   logic bclk_rise;
   logic we_rise;
   logic fill_valid;
   logic fill_ready;
   logic [15:0] fill_data;
   logic drain_valid;
   logic drain_ready;
   logic [15:0] drain_data;
   logic fifo_clr;

   // wrap the address inside the burst group
   function automatic logic [15:0] next_addr(input logic [15:0] a, input logic [2:0] bl);
      logic [15:0] m;
      case (bl)
         `FHRP_BL_4: m = `FHRP_MASK_4;
         `FHRP_BL_8: m = `FHRP_MASK_8;
         `FHRP_BL_16: m = `FHRP_MASK_16;
         `FHRP_BL_32: m = `FHRP_MASK_32;
         default: m = `FHRP_MASK_CONT;
      endcase
      next_addr = (a & ~m) | ((a + `FHRP_ADDR_ONE) & m); // RULE5
   endfunction

   // inclusive address range test
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // address phase: strobe and select low, write strobe high
   function automatic logic addr_phase(input logic avd_n, input logic ce_n, input logic we_n);
      addr_phase = !avd_n && !ce_n && we_n;
   endfunction

   // start address refused for synchronous reads
   function automatic logic sync_refused(input logic [15:0] a, input logic [2:0] bl);
      logic rsv;
      logic spare32;
      rsv = in_range(a, `FHRP_RSV_MAIN_LO, `FHRP_RSV_MAIN_HI)
         || in_range(a, `FHRP_RSV_SPARE_LO, `FHRP_RSV_SPARE_HI)
         || in_range(a, `FHRP_RSV_REG_LO, `FHRP_RSV_REG_HI); // RULE13
      spare32 = (bl == `FHRP_BL_32) && in_range(a, `FHRP_BUF_SPARE_LO, `FHRP_BUF_SPARE_HI); // RULE16
      sync_refused = rsv || spare32;
   endfunction

   // word at an address: configuration register or buffer memory
   function automatic logic [15:0] rd_word(input logic [15:0] a, input logic [15:0] cfg,
                                           input logic [15:0] mw);
      rd_word = (a == `FHRP_CFG_ADDR) ? cfg : mw; // RULE8
   endfunction

   // all pins pass two flops before use
   fhrp_sync #(.W(6), .INIT(SYNC_INIT)) u_sync_ctl (
      .clk(CLOCK),
      .rst_n(RESET_N),
      .d({HARDWARE_RESET_N, ADDRESS_VALID_STROBE_N, CHIP_SELECT_N, OUTPUT_ENABLE_N,
          WRITE_STROBE_N, BURST_CLK}),
      .q(ctl_s)
   );

   fhrp_sync #(.W(32), .INIT(32'h00000000)) u_sync_bus (
      .clk(CLOCK),
      .rst_n(RESET_N),
      .d({ADDRESS_LINES, DATA_LINES_IN}),
      .q({addr_s, din_s})
   );

   assign hrst_n_s = ctl_s[CTL_HRST];
   assign avd_n_s = ctl_s[CTL_AVD];
   assign ce_n_s = ctl_s[CTL_CE];
   assign oe_n_s = ctl_s[CTL_OE];
   assign we_n_s = ctl_s[CTL_WE];
   assign bclk_s = ctl_s[CTL_BCLK];

   // warm reset from the pin joins the system reset
   assign warm_rst_n = RESET_N && hrst_n_s; // RULE19

   // edges of sampled burst clock and write strobe
   assign bclk_rise = bclk_s && !r_reg.bclk_d;
   assign we_rise = we_n_s && !r_reg.we_d;

   // prefetch path: memory words queued ahead of the burst clock
   assign fill_valid = (r_reg.state != fhrp_pkg::FHRP_IDLE);
   assign fill_data = rd_word(r_reg.fill_addr, r_reg.cfg, mem[r_reg.fill_addr[MEM_AW-1:0]]);
   assign fifo_clr = (r_reg.state == fhrp_pkg::FHRP_IDLE); // RULE20

   fhrp_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CLOCK),
      .rst_n(warm_rst_n),
      .clr(fifo_clr),
      .in_valid(fill_valid),
      .in_ready(fill_ready),
      .in_data(fill_data),
      .out_valid(drain_valid),
      .out_ready(drain_ready),
      .out_data(drain_data)
   );

   // next state of the port
   always_comb begin
      logic [3:0] burst_latency_count;
      logic [2:0] bl;
      logic sync_mode;
      logic leave;
      r_next = r_reg;
      burst_latency_count = {1'b0, r_reg.cfg[`FHRP_BRL_MSB:`FHRP_BRL_LSB]};
      bl = r_reg.cfg[`FHRP_BL_MSB:`FHRP_BL_LSB];
      sync_mode = r_reg.cfg[`FHRP_RM_BIT];
      leave = ce_n_s || !we_n_s || !avd_n_s; // RULE12
      drain_ready = 1'b0;
      r_next.bclk_d = bclk_s;
      r_next.we_d = we_n_s;

      // register write at the end of a write pulse
      if (we_rise && !ce_n_s && r_reg.addr == `FHRP_CFG_ADDR) begin
         r_next.cfg = din_s; // RULE2 RULE7
      end

      // queue advances while the fifo accepts
      if (fill_valid && fill_ready) begin
         r_next.fill_addr = next_addr(r_reg.fill_addr, bl); // RULE11
      end

      case (r_reg.state)
         // waiting for an address phase
         fhrp_pkg::FHRP_IDLE: begin
            r_next.cnt = `FHRP_CNT_ZERO;
            r_next.rdy = 1'b0;
            // address latched while strobe and select are low
            if (addr_phase(avd_n_s, ce_n_s, we_n_s)) begin
               r_next.addr = addr_s; // RULE3
            end
            // word for the held address, with no command needed
            r_next.data_out = rd_word(r_next.addr, r_reg.cfg,
                                      mem[r_next.addr[MEM_AW-1:0]]); // RULE1 RULE3 RULE10
            // clocked latch starts a burst in synchronous mode
            if (sync_mode && bclk_rise && addr_phase(avd_n_s, ce_n_s, we_n_s)
                && !sync_refused(addr_s, bl)) begin
               r_next.state = fhrp_pkg::FHRP_LATENCY; // RULE4
               r_next.fill_addr = next_addr(addr_s, bl);
               r_next.data_out = rd_word(addr_s, r_reg.cfg, mem[addr_s[MEM_AW-1:0]]); // RULE6
            end
         end
         // counting latency edges of the burst clock
         fhrp_pkg::FHRP_LATENCY: begin
            if (leave) begin
               r_next.state = fhrp_pkg::FHRP_IDLE; // RULE20
               r_next.cnt = `FHRP_CNT_ZERO;
               r_next.rdy = 1'b0;
            end else if (bclk_rise) begin
               if (r_reg.cnt == burst_latency_count) begin
                  // edge n+1: first word taken, next word presented
                  r_next.rdy = 1'b0;
                  r_next.state = fhrp_pkg::FHRP_STREAM; // RULE14
                  drain_ready = 1'b1;
                  if (drain_valid) begin
                     r_next.data_out = drain_data; // RULE15
                  end
               end else begin
                  r_next.cnt = r_reg.cnt + `FHRP_CNT_ONE;
                  // ready rises at edge n, one edge ahead of the fetch
                  if (r_reg.cnt + `FHRP_CNT_ONE == burst_latency_count) begin
                     r_next.rdy = 1'b1; // RULE9
                  end
               end
            end
         end
         // one word per burst clock edge
         fhrp_pkg::FHRP_STREAM: begin
            if (leave) begin
               r_next.state = fhrp_pkg::FHRP_IDLE; // RULE12 RULE20
               r_next.cnt = `FHRP_CNT_ZERO;
            end else if (bclk_rise) begin
               // every later edge brings the next word
               drain_ready = 1'b1;
               if (drain_valid) begin
                  r_next.data_out = drain_data; // RULE11 RULE15
               end
            end
         end
         default: begin
            r_next.state = fhrp_pkg::FHRP_IDLE;
         end
      endcase
   end

   // state register, warm reset restores defaults
   always_ff @(posedge CLOCK) begin
      if (!warm_rst_n) begin
         r_reg.state <= fhrp_pkg::FHRP_IDLE; // RULE1
         r_reg.cfg <= `FHRP_CFG_RESET; // RULE7 RULE19
         r_reg.addr <= '0;
         r_reg.fill_addr <= '0;
         r_reg.cnt <= `FHRP_CNT_ZERO;
         r_reg.rdy <= 1'b0;
         r_reg.data_out <= '0;
         r_reg.bclk_d <= 1'b0;
         r_reg.we_d <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // buffer memory, untouched by any reset
   always_ff @(posedge CLOCK) begin
      if (we_rise && !ce_n_s && r_reg.addr != `FHRP_CFG_ADDR) begin
         mem[r_reg.addr[MEM_AW-1:0]] <= din_s; // RULE19
      end
   end

   // pins
   assign DATA_LINES_OUT = r_reg.data_out;
   assign DATA_LINES_OE_N = ce_n_s || oe_n_s || !we_n_s; // RULE18
   assign READY = r_reg.rdy;

endmodule

`default_nettype wire

// File: fhrp_top_properties.sv
`timescale 1ns/1ps
`default_nettype none

module fhrp_chk (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESET_N,
   // host strobes
   input wire logic HARDWARE_RESET_N,
   input wire logic CHIP_SELECT_N,
   input wire logic OUTPUT_ENABLE_N,
   input wire logic WRITE_STROBE_N,
   // device outputs
   input wire logic [15:0] DATA_LINES_OUT,
   input wire logic DATA_LINES_OE_N,
   input wire logic READY
);
   // one clock domain for every check
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESET_N);

   // output drive against the selects, pins pass two sync flops
   property p_ce_off; CHIP_SELECT_N [*4] |-> DATA_LINES_OE_N; endproperty
   a_ce_off: assert property (p_ce_off) else $error("driven while deselected");
   property p_oe_off; OUTPUT_ENABLE_N [*4] |-> DATA_LINES_OE_N; endproperty
   a_oe_off: assert property (p_oe_off) else $error("driven while output off");
   property p_drive; (!CHIP_SELECT_N && !OUTPUT_ENABLE_N && WRITE_STROBE_N) [*4] |-> !DATA_LINES_OE_N; endproperty
   a_drive: assert property (p_drive) else $error("read not driven");
   // reset values
   property p_rst; $rose(RESET_N) |-> !READY && DATA_LINES_OUT == 16'h0000; endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared");
   property p_hw; !HARDWARE_RESET_N [*5] |-> !READY && DATA_LINES_OUT == 16'h0000; endproperty
   a_hw: assert property (p_hw) else $error("pin reset ignored");
   // ready pulse and the first word under it
   property p_rdy_len; $rose(READY) |-> READY [*4]; endproperty
   a_rdy_len: assert property (p_rdy_len) else $error("ready too short");
   property p_rdy_hold; READY && $past(READY) |-> $stable(DATA_LINES_OUT); endproperty
   a_rdy_hold: assert property (p_rdy_hold) else $error("word moved under ready");
   property p_rdy_src; $rose(READY) |-> !$past(CHIP_SELECT_N, 3) && $past(WRITE_STROBE_N, 3); endproperty
   a_rdy_src: assert property (p_rdy_src) else $error("ready without burst");
   // burst termination
   property p_we_end; !WRITE_STROBE_N [*5] |-> !READY; endproperty
   a_we_end: assert property (p_we_end) else $error("burst kept on write");
   property p_ce_end; CHIP_SELECT_N [*5] |-> !READY; endproperty
   a_ce_end: assert property (p_ce_end) else $error("burst kept deselected");
endmodule

bind fhrp_top fhrp_chk fhrp_chk_inst (.CLOCK, .RESET_N, .HARDWARE_RESET_N, .CHIP_SELECT_N, .OUTPUT_ENABLE_N,
   .WRITE_STROBE_N, .DATA_LINES_OUT, .DATA_LINES_OE_N, .READY);

`default_nettype wire

// File: fhrp_host.sv
`timescale 1ns/1ps
`default_nettype none

module fhrp_host (
   // clock and read data
   input wire logic clk,
   input wire logic [15:0] dout,
   // host pins
   output logic bclk,
   output logic hrst_n,
   output logic avd_n,
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic [15:0] addr,
   output logic [15:0] din
);
   // pins move only on falling edges
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask
   // release every strobe
   task automatic idle();
      ce_n = 1'b1;
      oe_n = 1'b1;
      avd_n = 1'b1;
      we_n = 1'b1;
   endtask
   // one burst clock period, parked low between frames
   task automatic tick();
      bclk = 1'b1;
      wait_n(4);
      bclk = 1'b0;
      wait_n(4);
   endtask
   // address under the strobe, write strobe high
   task automatic latch(input logic [15:0] a, input logic oe);
      ce_n = 1'b0;
      oe_n = oe;
      we_n = 1'b1;
      avd_n = 1'b0;
      addr = a;
      wait_n(4);
   endtask
   // word write, data held past the write strobe rise
   task automatic write(input logic [15:0] a, input logic [15:0] d);
      latch(a, 1'b1);
      avd_n = 1'b1;
      din = d;
      we_n = 1'b0;
      wait_n(6);
      we_n = 1'b1;
      wait_n(4);
      din = ~d;
      idle();
      wait_n(4);
   endtask
   // asynchronous word read
   task automatic read(input logic [15:0] a, output logic [15:0] d);
      latch(a, 1'b0);
      wait_n(6);
      d = dout;
      idle();
      wait_n(4);
   endtask
   // burst start: address latched on the first clock
   task automatic start(input logic [15:0] a);
      latch(a, 1'b0);
      bclk = 1'b1;
      wait_n(1);
      avd_n = 1'b1; // strobe let go one clock after the rise, before the device sees the edge
      wait_n(3);
      bclk = 1'b0;
      wait_n(4);
   endtask
   // write strobe pulse with select held, ends a burst
   task automatic wpulse();
      we_n = 1'b0;
      wait_n(6);
      we_n = 1'b1;
      wait_n(4);
   endtask
   // pin reset longer than its minimum
   task automatic hw_reset();
      hrst_n = 1'b0;
      wait_n(12);
      hrst_n = 1'b1;
      wait_n(6);
   endtask
   // quiet pins at time zero
   initial begin
      idle();
      bclk = 1'b0;
      hrst_n = 1'b1;
      addr = 16'h0000;
      din = 16'h0000;
   end
endmodule

`default_nettype wire

// File: fhrp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fhrp_consts.svh"

module fhrp_top_tb;
   // clock, reset and pins
   logic clk;
   logic rst_n;
   logic bclk, hrst_n, avd_n, ce_n, oe_n, we_n, oe_out, rdy;
   logic [15:0] addr, din, dout, rd;
   int n_mismatch = 0;
   int total_checks = 0;

   fhrp_top fhrp_top_inst (.CLOCK(clk), .RESET_N(rst_n), .HARDWARE_RESET_N(hrst_n), .BURST_CLK(bclk),
      .ADDRESS_VALID_STROBE_N(avd_n), .CHIP_SELECT_N(ce_n), .OUTPUT_ENABLE_N(oe_n), .WRITE_STROBE_N(we_n),
      .ADDRESS_LINES(addr), .DATA_LINES_IN(din), .DATA_LINES_OUT(dout), .DATA_LINES_OE_N(oe_out), .READY(rdy));
   fhrp_host fhrp_host_inst (.clk(clk), .dout(dout), .bclk(bclk), .hrst_n(hrst_n), .avd_n(avd_n), .ce_n(ce_n),
      .oe_n(oe_n), .we_n(we_n), .addr(addr), .din(din));

   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (n_mismatch == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // memory pattern
   function automatic logic [15:0] wv(input logic [15:0] a);
      return a ^ 16'h5ac3;
   endfunction

   // burst with n latency edges, words taken at end of each period
   task automatic burst_run(input logic [15:0] a, input logic [2:0] n, input logic [15:0] mask);
      logic [15:0] ea;
      fhrp_host_inst.start(a);
      check(dout, wv(a));
      check(oe_out, 1'b0);
      for (int k = 1; k <= n + 5; k++) begin
         fhrp_host_inst.tick();
         ea = (k <= n) ? a : (a & ~mask) | ((a + 16'(k - n)) & mask);
         check(dout, wv(ea));
         check(rdy, 16'(k == n));
      end
      fhrp_host_inst.idle();
      fhrp_host_inst.wait_n(4);
   endtask
   // start refused: no ready over eight periods, past latency seven
   task automatic no_ready(input logic [15:0] a);
      fhrp_host_inst.start(a);
      repeat (8) begin
         fhrp_host_inst.tick();
         check(rdy, 1'b0);
      end
      fhrp_host_inst.idle();
      fhrp_host_inst.wait_n(4);
   endtask

   // reset state
   task automatic t_reset();
      check(oe_out, 1'b1);
      check(rdy, 1'b0);
      fhrp_host_inst.read(`FHRP_CFG_ADDR, rd);
      check(rd[`FHRP_RM_BIT], 1'b0);
      check(rd[`FHRP_BRL_MSB:`FHRP_BRL_LSB], 3'h4);
   endtask
   // fill, read back, clocked access in async mode
   task automatic t_async();
      for (int a = 16'h0200; a < 16'h0220; a++)
         fhrp_host_inst.write(16'(a), wv(16'(a)));
      fhrp_host_inst.read(16'h021f, rd);
      check(rd, wv(16'h021f));
      fhrp_host_inst.start(16'h0205);
      check(dout, wv(16'h0205));
      fhrp_host_inst.idle();
      fhrp_host_inst.wait_n(4);
   endtask
   // every burst length, latency three to seven
   task automatic t_modes();
      logic [15:0] cfg;
      for (int i = 0; i < 5; i++) begin
         cfg = {1'b1, 3'(3 + i), 3'(i), 9'h000};
         fhrp_host_inst.write(`FHRP_CFG_ADDR, cfg);
         fhrp_host_inst.read(`FHRP_CFG_ADDR, rd);
         check(rd, cfg);
         burst_run(16'h020e, 3'(3 + i), (i == 0) ? 16'hffff : (16'h0002 << i) - 16'h0001);
      end
   endtask
   // write pulse ends a burst, ticks alone never restart it
   task automatic t_term();
      fhrp_host_inst.start(16'h0210);
      fhrp_host_inst.tick();
      fhrp_host_inst.tick();
      fhrp_host_inst.wpulse();
      check(oe_out, 1'b0);
      repeat (8) begin
         fhrp_host_inst.tick();
         check(rdy, 1'b0);
      end
      fhrp_host_inst.idle();
      fhrp_host_inst.wait_n(4);
   endtask
   // pin reset keeps memory, restores config
   task automatic t_hw();
      fhrp_host_inst.hw_reset();
      fhrp_host_inst.read(`FHRP_CFG_ADDR, rd);
      check(rd, `FHRP_CFG_RESET);
      fhrp_host_inst.read(16'h0203, rd);
      check(rd, wv(16'h0203));
   endtask

   // clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // main sequence, 32-word config left set for the refused starts
   initial begin
      rst_n = 1'b0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      t_async();
      t_modes();
      t_term();
      no_ready(16'h8010);
      no_ready(16'h0a00);
      t_hw();
      give_verdict();
   end
   // watchdog
   initial begin
      #400000;
      n_mismatch++;
      give_verdict();
   end
endmodule

`default_nettype wire
